// [nco_amp_if.sv]
// Truncated phase to amplitude path between core and mapper
`timescale 1ns/1ps
interface nco_amp_if;
	import nco_pkg::*;
	logic [PHASE_TRUNC_W-1:0] phase;
	logic [AMP_W-1:0]         amp;
	modport core   (output phase, input amp);
	modport mapper (input phase, output amp);
endinterface

// [nco_core.sv]
// Phase accumulator oscillator core with clock monitor and update staging
`timescale 1ns/1ps
module nco_core
	import nco_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 reference_clock_in,
	input  wire logic                 word_load_strobe,
	input  wire logic [IN_WORD_W-1:0] load_word,
	input  wire logic                 apply_update_strobe,
	output logic      [AMP_W-1:0]     amp_sample,
	output logic                      amp_sample_valid,
	output logic                      comparator_enable,
	output logic                      power_down,
	output logic                      clock_too_slow,
	output logic                      clock_times_six_multiplier
);
	typedef struct packed {
		logic                 ref_s1, ref_s2, ref_d;
		logic                 ld_s1, ld_s2, ld_d;
		logic [IN_WORD_W-1:0] ld_w1, ld_w2;
		logic                 up_s1, up_s2, up_d;
		logic [IN_WORD_W-1:0] in_word;
		logic [ACC_W-1:0]     stage_freq;
		logic [POFF_W-1:0]    stage_phase;
		logic [LAT_W-1:0]     freq_cnt;
		logic [LAT_W-1:0]     phase_cnt;
		logic [ACC_W-1:0]     ftw;
		logic [POFF_W-1:0]    phase_off;
		logic                 mult_en;
		logic                 pd_bit;
		logic [ACC_W-1:0]     acc;
		logic [CNT_W-1:0]     gap_cnt;
		logic [CNT_W-1:0]     period;
		logic [CNT_W-1:0]     div_cnt;
		logic [2:0]           sub_cnt;
		logic                 slow;
		logic [CNT_W-1:0]     resume_cnt;
		logic [AMP_W-1:0]     sample;
		logic                 sample_valid;
		logic                 comp_en;
		logic                 pd_out;
	} nco_state_t;

	nco_state_t       s_r;
	nco_state_t       s_nxt;
	logic             ref_edge;
	logic             ld_edge;
	logic             upd_edge;
	logic             tick;
	logic             pd_any;
	logic [CNT_W-1:0] gap_limit;
	logic [CNT_W-1:0] step;
	logic [POFF_W-1:0] top_sum;

	nco_amp_if amp_if ();

	nco_sine_map u_map
	(
		.amp_if (amp_if)
	);

	assign ref_edge  = s_r.ref_s2 & ~s_r.ref_d;
	assign ld_edge   = s_r.ld_s2 & ~s_r.ld_d;
	assign upd_edge  = s_r.up_s2 & ~s_r.up_d;
	assign gap_limit = s_r.mult_en ? GAP_LIMIT_MULT : GAP_LIMIT_DIRECT;
	assign step      = (s_r.period / CNT_W'(MULT_FACTOR) == '0) ? CNT_W'(1) : s_r.period / CNT_W'(MULT_FACTOR);
	assign pd_any    = s_r.pd_bit | s_r.slow;
	// Multiplied mode fills each reference period of six or more clocks with six ticks, period/6 clocks apart
	assign tick      = ref_edge | (s_r.mult_en & (s_r.div_cnt + CNT_W'(1) >= step)
		& (s_r.sub_cnt < MULT_FACTOR - 3'h1));
	assign top_sum   = s_r.acc[ACC_W-1 -: POFF_W] + s_r.phase_off;
	assign amp_if.phase = {top_sum, s_r.acc[ACC_W-POFF_W-1 -: PHASE_TRUNC_W-POFF_W]};

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.ref_s1 = reference_clock_in;
		s_nxt.ref_s2 = s_r.ref_s1;
		s_nxt.ref_d  = s_r.ref_s2;
		s_nxt.ld_s1  = word_load_strobe;
		s_nxt.ld_s2  = s_r.ld_s1;
		s_nxt.ld_d   = s_r.ld_s2;
		s_nxt.ld_w1  = load_word;
		s_nxt.ld_w2  = s_r.ld_w1;
		s_nxt.up_s1  = apply_update_strobe;
		s_nxt.up_s2  = s_r.up_s1;
		s_nxt.up_d   = s_r.up_s2;
		s_nxt.sample_valid = 1'b0;
		// Bus synchronised beside the strobe, so it need only be steady at the clock that first samples the rise
		if (ld_edge)
			s_nxt.in_word = s_r.ld_w2;
		// Reference period and gap monitor
		if (ref_edge)
		begin
			s_nxt.gap_cnt = '0;
			s_nxt.period  = s_r.gap_cnt + CNT_W'(1);
			s_nxt.div_cnt = '0;
			s_nxt.sub_cnt = '0;
		end
		else
		begin
			if (s_r.gap_cnt != '1)
				s_nxt.gap_cnt = s_r.gap_cnt + CNT_W'(1);
			if (tick)
			begin
				s_nxt.div_cnt = '0;
				s_nxt.sub_cnt = s_r.sub_cnt + 3'h1;
			end
			else if (s_r.div_cnt != '1)
				s_nxt.div_cnt = s_r.div_cnt + CNT_W'(1);
		end
		if (s_r.gap_cnt >= gap_limit)
		begin
			s_nxt.slow       = 1'b1;
			s_nxt.resume_cnt = '0;
		end
		else if (s_r.slow)
		begin
			s_nxt.resume_cnt = s_r.resume_cnt + CNT_W'(1);
			if (s_r.resume_cnt == RESUME_CYC - CNT_W'(1))
				s_nxt.slow = 1'b0;
		end
		s_nxt.comp_en = ~pd_any;
		// Update: control bits at once, frequency and phase after their latencies
		if (upd_edge)
		begin
			s_nxt.mult_en     = s_r.in_word[FLD_MULT_EN];
			s_nxt.pd_bit      = s_r.in_word[FLD_PD];
			s_nxt.stage_phase = s_r.in_word[FLD_PHASE_LSB +: POFF_W];
			s_nxt.stage_freq  = s_r.in_word[FLD_FREQ_LSB +: ACC_W];
			s_nxt.freq_cnt    = FREQ_LAT;
			s_nxt.phase_cnt   = PHASE_LAT;
		end
		else if (tick && !pd_any)
		begin
			if (s_r.freq_cnt != '0)
				s_nxt.freq_cnt = s_r.freq_cnt - LAT_W'(1);
			if (s_r.freq_cnt == LAT_W'(1))
				s_nxt.ftw = s_r.stage_freq;
			if (s_r.phase_cnt != '0)
				s_nxt.phase_cnt = s_r.phase_cnt - LAT_W'(1);
			if (s_r.phase_cnt == LAT_W'(1))
				s_nxt.phase_off = s_r.stage_phase;
		end
		// Frozen while powered down, settings retained
		if (tick && !pd_any)
		begin
			s_nxt.acc          = s_r.acc + s_r.ftw;
			s_nxt.sample       = amp_if.amp;
			s_nxt.sample_valid = 1'b1;
		end
		// Registered copy so the pin leaves straight from a flop
		s_nxt.pd_out = s_nxt.pd_bit | s_nxt.slow;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			s_r         <= '0;
			s_r.in_word <= s_r.in_word;
		end
		else
			s_r <= s_nxt;
	end

	assign amp_sample                 = s_r.sample;
	assign amp_sample_valid           = s_r.sample_valid;
	assign comparator_enable          = s_r.comp_en;
	assign power_down                 = s_r.pd_out;
	assign clock_too_slow             = s_r.slow;
	assign clock_times_six_multiplier = s_r.mult_en;

	sequence upd_seen_s;
		upd_edge;
	endsequence

	sequence lat_loaded_s;
		s_r.freq_cnt == FREQ_LAT && s_r.phase_cnt == PHASE_LAT;
	endsequence

	acc_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && !pd_any |=> s_r.acc == $past(s_r.acc) + $past(s_r.ftw))
		else $error("accumulator did not advance by tuning word");
	reset_clear_a: assert property (@(posedge core_clk)
		!rst_n |=> s_r.acc == '0 && s_r.phase_off == '0 && !s_r.mult_en && $stable(s_r.in_word))
		else $error("reset left state or changed input word");
	update_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		upd_seen_s |=> lat_loaded_s and s_r.stage_freq == $past(s_r.in_word[FLD_FREQ_LSB +: ACC_W]))
		else $error("update did not stage input word");
	freq_apply_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_r.freq_cnt == LAT_W'(1) && tick && !pd_any && !upd_edge |=> s_r.ftw == $past(s_r.stage_freq))
		else $error("tuning word not applied at latency end");
	phase_apply_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_r.phase_cnt == LAT_W'(1) && tick && !pd_any && !upd_edge |=> s_r.phase_off == $past(s_r.stage_phase))
		else $error("phase word not applied at latency end");
	slow_detect_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_r.gap_cnt >= gap_limit |=> s_r.slow ##1 power_down)
		else $error("slow reference did not force power-down");
	comp_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_r.slow [*2] |-> !comparator_enable)
		else $error("comparator left on in slow-clock power-down");
	freeze_acc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		pd_any |=> $stable(s_r.acc) && !amp_sample_valid)
		else $error("accumulator moved while powered down");
	resume_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(s_r.slow) |-> $past(s_r.resume_cnt) == RESUME_CYC - CNT_W'(1))
		else $error("resumed before delay elapsed");
endmodule

// [nco_core_tb.sv]
// Self-checking bench for the oscillator core
`timescale 1ns/1ps
module nco_core_tb;
	import nco_pkg::*;
	typedef struct packed { logic [IN_WORD_W-1:0] w; logic [3:0] exp; } nco_row_t;
	logic                 core_clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 reference_clock_in = 1'b0;
	logic                 ref_run = 1'b1;
	logic                 word_load_strobe, apply_update_strobe;
	logic [IN_WORD_W-1:0] load_word;
	logic [AMP_W-1:0]     amp_sample, a, p;
	logic [AMP_W-1:0]     hist [4];
	logic                 amp_sample_valid, comparator_enable, power_down, clock_too_slow, clock_times_six_multiplier;
	int                   error_cnt = 0;
	int                   samples_checked = 0;
	int                   n;
	logic                 moved;
	// Flags as {multiplier, power_down, comparator_enable, too_slow}
	nco_row_t rows [5] = '{'{40'h00_0000_0000, 4'h2}, '{40'h00_0000_0004, 4'h4}, '{40'h00_0000_0002, 4'h2},
		'{40'h00_0000_0000, 4'h2}, '{40'h00_0000_0001, 4'hD}};
	always #50 core_clk = ~core_clk;
	// Reference at 2.5 MHz: fine direct, too slow when multiplied
	always #200 reference_clock_in = ref_run ? ~reference_clock_in : 1'b0;
	nco_ctl_model i_ctl (.core_clk(core_clk), .word_load_strobe(word_load_strobe), .load_word(load_word),
		.apply_update_strobe(apply_update_strobe));
	nco_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .reference_clock_in(reference_clock_in),
		.word_load_strobe(word_load_strobe), .load_word(load_word), .apply_update_strobe(apply_update_strobe),
		.amp_sample(amp_sample), .amp_sample_valid(amp_sample_valid), .comparator_enable(comparator_enable),
		.power_down(power_down), .clock_too_slow(clock_too_slow),
		.clock_times_six_multiplier(clock_times_six_multiplier));
	task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask
	task automatic do_reset();
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
	endtask
	// Bounded wait for the next sample strobe
	task automatic tick(output logic [AMP_W-1:0] s);
		repeat (40)
		begin
			@(negedge core_clk);
			if (amp_sample_valid === 1'b1)
				break;
		end
		chk("tick", 1'b1, amp_sample_valid);
		s = amp_sample;
	endtask
	function automatic logic [3:0] flags();
		return {clock_times_six_multiplier, power_down, comparator_enable, clock_too_slow};
	endfunction
	initial
	begin
		#2_500_000;
		error_cnt++;
		give_verdict();
	end
	initial
	begin
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk("reset outputs", 0, {amp_sample, amp_sample_valid, flags()});
		@(posedge core_clk);
		rst_n <= 1'b1;
		foreach (rows[i])
		begin
			i_ctl.load(rows[i].w);
			i_ctl.update();
			cyc(20);
			chk("flags", rows[i].exp, flags());
		end
		do_reset();
		cyc(2);
		chk("mult after reset", 0, clock_times_six_multiplier);
		i_ctl.update();
		cyc(6);
		chk("input word kept", 1, clock_times_six_multiplier);
		do_reset();
		ref_run = 1'b0;
		cyc(20);
		chk("slow stop", 3'h5, {power_down, comparator_enable, clock_too_slow});
		ref_run = 1'b1;
		cyc(20);
		chk("slow hold", 1, clock_too_slow);
		cyc(50);
		chk("slow clear", 3'h2, {power_down, comparator_enable, clock_too_slow});
		tick(a);
		chk("midscale", AMP_MID, a);
		i_ctl.load(40'h00_0000_0040);
		i_ctl.update();
		for (n = 1; n <= 16; n++)
		begin
			tick(a);
			if (n <= 13)
				chk("phase early", AMP_MID, a);
			if (n == 15)
				p = a;
		end
		chk("phase step", 10'h3FF, p);
		chk("phase steady", p, a);
		i_ctl.load(40'h40_0000_0040);
		i_ctl.update();
		moved = 1'b0;
		for (n = 1; n <= 27; n++)
		begin
			tick(a);
			if (n <= 19)
				chk("freq early", p, a);
			if (n == 21)
				chk("trough", 10'h001, a);
			if (n >= 20 && n < 24)
				hist[n-20] = a;
			if (n >= 24)
				chk("wrap period", hist[n-24], a);
			if (n >= 20 && a !== p)
				moved = 1'b1;
		end
		chk("freq applied", 1, moved);
		// Direct mode: one sample per reference period of four clocks
		n = 0;
		repeat (40)
		begin
			@(negedge core_clk);
			if (amp_sample_valid === 1'b1)
				n++;
		end
		chk("direct rate", 10, n);
		i_ctl.load(40'h40_0000_0044);
		i_ctl.update();
		cyc(5);
		n = 0;
		repeat (40)
		begin
			@(negedge core_clk);
			if (amp_sample_valid === 1'b1)
				n++;
		end
		chk("frozen", 0, n);
		i_ctl.load(40'h40_0000_0040);
		i_ctl.update();
		tick(a);
		give_verdict();
	end
endmodule

// [nco_ctl_model.sv]
// Behavioural controller that loads and applies words over the strobe pins
`timescale 1ns/1ps
module nco_ctl_model
	import nco_pkg::*;
(
	input  wire logic                 core_clk,
	output logic                      word_load_strobe,
	output logic      [IN_WORD_W-1:0] load_word,
	output logic                      apply_update_strobe
);
	initial
	begin
		word_load_strobe    = 1'b0;
		apply_update_strobe = 1'b0;
		load_word           = '0;
	end
	// Word held past the synchroniser, then scrambled so nothing leans on stale data
	task automatic load(input logic [IN_WORD_W-1:0] w);
		@(posedge core_clk);
		load_word        <= w;
		word_load_strobe <= 1'b1;
		repeat (4) @(posedge core_clk);
		word_load_strobe <= 1'b0;
		repeat (3) @(posedge core_clk);
		load_word        <= ~w;
	endtask
	// One shared strobe per batch of loads
	task automatic update();
		@(posedge core_clk);
		apply_update_strobe <= 1'b1;
		repeat (3) @(posedge core_clk);
		apply_update_strobe <= 1'b0;
		@(posedge core_clk);
	endtask
endmodule

// [nco_pkg.sv]
// Constants shared by the oscillator core and its amplitude mapper
package nco_pkg;
	localparam int unsigned ACC_W          = 32;
	localparam int unsigned PHASE_TRUNC_W  = 14;
	localparam int unsigned AMP_W          = 10;
	localparam int unsigned POFF_W         = 5;
	localparam int unsigned IN_WORD_W      = 40;
	localparam int unsigned CNT_W          = 8;
	localparam int unsigned LAT_W          = 5;
	// Field layout of the 40-bit input word
	localparam int unsigned FLD_MULT_EN    = 0;
	localparam int unsigned FLD_PD         = 2;
	localparam int unsigned FLD_PHASE_LSB  = 3;
	localparam int unsigned FLD_FREQ_LSB   = 8;
	// Timing
	localparam int unsigned CORE_HZ        = 10_000_000;
	localparam int unsigned CORE_PERIOD_NS = 100;
	localparam int unsigned MIN_REF_DIRECT_HZ = 1_000_000;
	localparam int unsigned MIN_REF_MULT_HZ   = 5_000_000;
	localparam int unsigned RESUME_NS      = 5_000;
	localparam logic [CNT_W-1:0] GAP_LIMIT_DIRECT = CNT_W'(CORE_HZ / MIN_REF_DIRECT_HZ);
	localparam logic [CNT_W-1:0] GAP_LIMIT_MULT   = CNT_W'(CORE_HZ / MIN_REF_MULT_HZ);
	localparam logic [CNT_W-1:0] RESUME_CYC =
		CNT_W'((RESUME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
	localparam logic [2:0] MULT_FACTOR     = 3'h6;
	localparam logic [LAT_W-1:0] FREQ_LAT  = 5'h12;
	localparam logic [LAT_W-1:0] PHASE_LAT = 5'h0D;
	localparam logic [AMP_W-1:0] AMP_MID   = 10'h200;
	localparam logic [AMP_W-1:0] AMP_MAG_MAX = 10'h1FF;
endpackage

// [nco_sine_map.sv]
// Phase to offset-binary sine amplitude, parabolic half-wave shaping
`timescale 1ns/1ps
module nco_sine_map
	import nco_pkg::*;
(
	nco_amp_if.mapper amp_if
);
	logic [12:0]      half;
	logic [25:0]      prod;
	logic [AMP_W-1:0] mag;

	// Parabola 4x(1-x) per half cycle: no table, about 5 % peak error
	always_comb
	begin
		half = amp_if.phase[12:0];
		prod = {13'h0000, half} * (26'h000_2000 - {13'h0000, half});
		mag  = prod[24] ? AMP_MAG_MAX : prod[24:15];
		amp_if.amp = amp_if.phase[13] ? (AMP_MID - mag) : (AMP_MID + mag);
	end
endmodule
